// File: logic/light_alert_map.vh
// Purpose: register map, field positions and reset values of the light threshold alert logic
// Assumes: 32-bit AXI4-Lite register bus, one aligned word per register
// Notes: definitions only
`ifndef LIGHT_ALERT_MAP_VH
`define LIGHT_ALERT_MAP_VH

// register byte offsets
`define CFG_ADDR 4'h0
`define HIGH_LIMIT_ADDR 4'h4
`define LOW_LIMIT_ADDR 4'h8
`define STATUS_ADDR 4'hC

// configuration field positions
`define CFG_FAULT_LSB 0
`define CFG_POLARITY_BIT 3
`define CFG_LATCH_BIT 4
`define CFG_FLAG_LOW_BIT 5
`define CFG_FLAG_HIGH_BIT 6
`define CFG_READY_BIT 7
`define CFG_MODE_LSB 9

// reset values
`define CFG_RESET 16'h0010
`define HIGH_LIMIT_RESET 16'hBFFF
`define LOW_LIMIT_RESET 16'h0000

// low limit top bits that select end-of-conversion operation, and the shutdown mode value
`define EOC_CODE 2'h3
`define MODE_SHUTDOWN 2'h0

// AXI responses
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2

`endif

// File: logic/fault_counter.v
// Purpose: counts consecutive conversions with the same fault result
// Assumes: convDone is a one-cycle pulse with isHigh/isLow valid in that cycle
// Notes: qualify pulses come one cycle after convDone
`timescale 1ns/10ps
`default_nettype none

module fault_counter (
  input wire sys_clk,
  input wire rst_b,
  input wire convDone,
  input wire isHigh,
  input wire isLow,
  input wire [1:0] faultSel,
  output reg highQual,
  output reg lowQual,
  output reg [3:0] runCount
);

  reg lastHigh_reg;
  reg [3:0] need;
  reg [3:0] runCount_next;

  // 00 -> 1, 01 -> 2, 10 -> 4, 11 -> 8 faults in a row
  always @* begin
    need = 4'h1 << faultSel;
  end

  // a fault in the other direction or no fault restarts the run
  always @* begin
    if (!isHigh && !isLow) begin
      runCount_next = 4'h0;
    end else if (runCount != 4'h0 && (isHigh == lastHigh_reg)) begin
      runCount_next = (runCount == 4'h8) ? 4'h8 : runCount + 4'h1;
    end else begin
      runCount_next = 4'h1;
    end
  end

  // run length, direction and qualify pulses
  always @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      runCount <= 4'h0;
      lastHigh_reg <= 1'b0;
      highQual <= 1'b0;
      lowQual <= 1'b0;
    end else begin
      highQual <= 1'b0;
      lowQual <= 1'b0;
      if (convDone) begin
        runCount <= runCount_next;
        lastHigh_reg <= isHigh;
        highQual <= isHigh && (runCount_next >= need);
        lowQual <= isLow && (runCount_next >= need);
      end
    end
  end

endmodule

`default_nettype wire

// File: logic/light_threshold_alert_logic.v
// Purpose: threshold alert logic of an ambient light sensor with AXI4-Lite registers
// Assumes: convDone pulses one cycle with convResult valid; alertResp pulses for an alert response
// Notes: alert pin is open drain; the pin value is always 0 and only the enable moves
`timescale 1ns/10ps
`default_nettype none
`include "light_alert_map.vh"

// Notes on behaviour
// - config bit 4 selects latched or transparent
// - low limit top bits 11b force end-of-conversion
// - latched: result outside limits counts fault
// - latched: qualified fault latches alert and flag
// - latched: config read clears alert and flags
// - latched: alert response clears only alert
// - latched high fault sets high flag, alert, ready
// - latched low fault sets low flag, alert, ready
// - outside end-of-conversion mode, unqualified conversion sets only ready
// - config read clears conversion ready
// - shutdown mode write keeps ready and alert
// - nonzero mode write clears ready, and alert in end-of-conversion mode
// - pull pin low when alert differs from polarity
// - transparent high fault: alert on, high flag
// - transparent low fault: alert off, low flag
// - transparent: config access keeps flags, and keeps alert outside end-of-conversion mode
// - transparent: no alert response answer
// - alert only after consecutive same faults
// - end-of-conversion: alert on every conversion
// - alert pin open drain only
module light_threshold_alert_logic (
  input wire sys_clk,
  input wire rst_b,
  input wire [3:0] s_axi_awaddr,
  input wire s_axi_awvalid,
  output reg s_axi_awready,
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  output reg s_axi_wready,
  output reg [1:0] s_axi_bresp,
  output reg s_axi_bvalid,
  input wire s_axi_bready,
  input wire [3:0] s_axi_araddr,
  input wire s_axi_arvalid,
  output reg s_axi_arready,
  output reg [31:0] s_axi_rdata,
  output reg [1:0] s_axi_rresp,
  output reg s_axi_rvalid,
  input wire s_axi_rready,
  input wire convDone,
  input wire [15:0] convResult,
  input wire alertResp,
  output reg alertRespAck,
  output reg alertPinOut,
  output reg alertPinOe
);

  reg [15:0] cfg_reg;
  reg [15:0] highLimit_reg;
  reg [15:0] lowLimit_reg;
  reg flagHigh_reg;
  reg flagLow_reg;
  reg convReady_reg;
  reg alertActive_reg;
  reg eocPending_reg;
  reg [3:0] awAddr_reg;
  reg [31:0] wData_reg;
  reg [3:0] wStrb_reg;
  reg awHeld_reg;
  reg wHeld_reg;
  wire [3:0] runCount;
  wire highQual;
  wire lowQual;
  wire latchSel;
  wire alertPolarity;
  wire [1:0] low_limit_top_bits;
  wire eocMode;
  wire doWrite;
  wire doRead;
  wire cfgRead;
  wire cfgWrite;
  wire [15:0] cfgWrData;
  wire cfgRunWrite;
  wire respTaken;
  reg [15:0] cfgView;
  reg [31:0] rdMux;
  reg rdOk;
  reg wrOk;

  assign latchSel = cfg_reg[`CFG_LATCH_BIT];
  assign alertPolarity = cfg_reg[`CFG_POLARITY_BIT];
  assign low_limit_top_bits = lowLimit_reg[15:14];
  assign eocMode = (low_limit_top_bits == `EOC_CODE);

  // bus events
  assign doWrite = awHeld_reg && wHeld_reg && !s_axi_bvalid;
  assign doRead = s_axi_arvalid && s_axi_arready;
  assign cfgRead = doRead && ({s_axi_araddr[3:2], 2'h0} == `CFG_ADDR);
  assign cfgWrite = doWrite && ({awAddr_reg[3:2], 2'h0} == `CFG_ADDR);
  assign cfgWrData[7:0] = wStrb_reg[0] ? wData_reg[7:0] : cfg_reg[7:0];
  assign cfgWrData[15:8] = wStrb_reg[1] ? wData_reg[15:8] : cfg_reg[15:8];
  assign cfgRunWrite = cfgWrite && (cfgWrData[`CFG_MODE_LSB+1:`CFG_MODE_LSB] != `MODE_SHUTDOWN);
  assign respTaken = alertResp && latchSel;

  // result outside the window counts as a fault
  fault_counter faults (
    .sys_clk(sys_clk),
    .rst_b(rst_b),
    .convDone(convDone),
    .isHigh(convResult > highLimit_reg),
    .isLow(convResult < lowLimit_reg),
    .faultSel(cfg_reg[`CFG_FAULT_LSB+1:`CFG_FAULT_LSB]),
    .highQual(highQual),
    .lowQual(lowQual),
    .runCount(runCount)
  );

  // write address and data are taken separately and held until the response
  always @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      s_axi_awready <= 1'b1;
      s_axi_wready <= 1'b1;
      awHeld_reg <= 1'b0;
      wHeld_reg <= 1'b0;
      awAddr_reg <= 4'h0;
      wData_reg <= 32'h0000_0000;
      wStrb_reg <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `RESP_OKAY;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        awAddr_reg <= s_axi_awaddr;
        awHeld_reg <= 1'b1;
        s_axi_awready <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        wData_reg <= s_axi_wdata;
        wStrb_reg <= s_axi_wstrb;
        wHeld_reg <= 1'b1;
        s_axi_wready <= 1'b0;
      end
      if (doWrite) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= wrOk ? `RESP_OKAY : `RESP_SLVERR;
      end
      if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
        awHeld_reg <= 1'b0;
        wHeld_reg <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready <= 1'b1;
      end
    end
  end

  // writable registers, status register is read only
  always @* begin
    wrOk = ({awAddr_reg[3:2], 2'h0} != `STATUS_ADDR);
  end

  // limit registers with byte lanes
  always @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      highLimit_reg <= `HIGH_LIMIT_RESET;
      lowLimit_reg <= `LOW_LIMIT_RESET;
    end else if (doWrite) begin
      if ({awAddr_reg[3:2], 2'h0} == `HIGH_LIMIT_ADDR) begin
        if (wStrb_reg[0]) highLimit_reg[7:0] <= wData_reg[7:0];
        if (wStrb_reg[1]) highLimit_reg[15:8] <= wData_reg[15:8];
      end
      if ({awAddr_reg[3:2], 2'h0} == `LOW_LIMIT_ADDR) begin
        if (wStrb_reg[0]) lowLimit_reg[7:0] <= wData_reg[7:0];
        if (wStrb_reg[1]) lowLimit_reg[15:8] <= wData_reg[15:8];
      end
    end
  end

  // configuration: flag and ready positions are status, not stored
  always @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      cfg_reg <= `CFG_RESET;
    end else if (cfgWrite) begin
      cfg_reg <= cfgWrData & 16'hFF1F;
    end
  end

  // configuration as software reads it
  always @* begin
    cfgView = cfg_reg;
    cfgView[`CFG_FLAG_HIGH_BIT] = flagHigh_reg;
    cfgView[`CFG_FLAG_LOW_BIT] = flagLow_reg;
    cfgView[`CFG_READY_BIT] = convReady_reg;
  end

  // read data select, all four word offsets are mapped, so every read answers OKAY
  always @* begin
    rdOk = 1'b1;
    case (s_axi_araddr[3:2])
      2'h0: rdMux = {16'h0000, cfgView};
      2'h1: rdMux = {16'h0000, highLimit_reg};
      2'h2: rdMux = {16'h0000, lowLimit_reg};
      2'h3: rdMux = {24'h00_0000, runCount, 1'b0, eocMode, latchSel, alertActive_reg};
      default: begin
        rdMux = 32'h0000_0000;
        rdOk = 1'b0;
      end
    endcase
  end

  // read channel: one read at a time, data one cycle after the address
  always @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= `RESP_OKAY;
    end else if (doRead) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= rdMux;
      s_axi_rresp <= rdOk ? `RESP_OKAY : `RESP_SLVERR;
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
      s_axi_arready <= 1'b1;
    end
  end

  // conversion ready: a finished conversion is checked first and wins over a clear
  always @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      convReady_reg <= 1'b0;
    end else if (convDone) begin
      convReady_reg <= 1'b1;
    end else if (cfgRead || cfgRunWrite) begin
      convReady_reg <= 1'b0;
    end
  end

  // qualify pulses arrive one cycle after convDone, remember the mode then
  always @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      eocPending_reg <= 1'b0;
    end else begin
      eocPending_reg <= convDone && eocMode;
    end
  end

  // alert and flags: clear terms first, set terms last so that a set wins
  always @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      alertActive_reg <= 1'b0;
      flagHigh_reg <= 1'b0;
      flagLow_reg <= 1'b0;
    end else begin
      if (cfgRead && (latchSel || eocMode)) begin
        alertActive_reg <= 1'b0;
      end
      if (cfgRead && latchSel) begin
        flagHigh_reg <= 1'b0;
        flagLow_reg <= 1'b0;
      end
      if (cfgRunWrite && eocMode) begin
        alertActive_reg <= 1'b0;
      end
      if (respTaken) begin
        alertActive_reg <= 1'b0;
      end
      if (eocPending_reg) begin
        alertActive_reg <= 1'b1;
      end else if (!eocMode && latchSel) begin
        if (highQual) begin
          flagHigh_reg <= 1'b1;
          alertActive_reg <= 1'b1;
        end
        if (lowQual) begin
          flagLow_reg <= 1'b1;
          alertActive_reg <= 1'b1;
        end
      end else if (!eocMode) begin
        if (highQual) begin
          alertActive_reg <= 1'b1;
          flagHigh_reg <= 1'b1;
          flagLow_reg <= 1'b0;
        end else if (lowQual) begin
          alertActive_reg <= 1'b0;
          flagLow_reg <= 1'b1;
          flagHigh_reg <= 1'b0;
        end
      end
    end
  end

  // open-drain pin: value fixed low, enable pulls the line
  always @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      alertPinOut <= 1'b0;
      alertPinOe <= 1'b0;
      alertRespAck <= 1'b0;
    end else begin
      alertPinOut <= 1'b0;
      alertPinOe <= alertPolarity ^ alertActive_reg;
      alertRespAck <= respTaken && alertActive_reg;
    end
  end

endmodule

`default_nettype wire

// File: sim/light_threshold_alert_logic_assertions.sv
// Purpose: port checks for the light threshold alert logic
// Assumes: address and data of a write are offered together
// Notes: mirrors polarity, latch and eoc bits from taken writes
`timescale 1ns/10ps
`default_nettype none
`include "light_alert_map.vh"
module light_threshold_alert_logic_assertions (
  input wire sys_clk,
  input wire rst_b,
  input wire [3:0] s_axi_awaddr,
  input wire s_axi_awvalid,
  input wire s_axi_awready,
  input wire [31:0] s_axi_wdata,
  input wire s_axi_wvalid,
  input wire s_axi_wready,
  input wire s_axi_bvalid,
  input wire s_axi_arvalid,
  input wire s_axi_arready,
  input wire s_axi_rvalid,
  input wire convDone,
  input wire alertResp,
  input wire alertRespAck,
  input wire alertPinOut,
  input wire alertPinOe
);
  reg polarityBit;
  reg latchBit;
  reg eocBit;
  wire wrTake;
  // a write counts once both halves are taken at one edge
  assign wrTake = s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  // mirror of the mode bits as written
  always @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      polarityBit <= 1'b0;
      latchBit <= 1'b1;
      eocBit <= 1'b0;
    end else if (wrTake && s_axi_awaddr == `CFG_ADDR) begin
      polarityBit <= s_axi_wdata[`CFG_POLARITY_BIT];
      latchBit <= s_axi_wdata[`CFG_LATCH_BIT];
    end else if (wrTake && s_axi_awaddr == `LOW_LIMIT_ADDR) begin
      eocBit <= s_axi_wdata[15:14] == `EOC_CODE;
    end
  end
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rst_b);
  a_pin_value_zero: assert property (!alertPinOut)
    else $error("alert pin value driven high");
  a_oe_reset_idle: assert property ($rose(rst_b) |-> !alertPinOe)
    else $error("alert pin pulled after reset");
  a_ack_after_resp: assert property (alertRespAck |-> $past(alertResp) || $past(alertResp, 2))
    else $error("ack without alert response");
  a_ack_only_latched: assert property (alertRespAck |-> latchBit)
    else $error("ack in transparent mode");
  a_ack_one_pulse: assert property (alertRespAck |=> !alertRespAck)
    else $error("ack longer than one cycle");
  a_eoc_alert_each: assert property (convDone && eocBit && latchBit && !polarityBit |-> ##[1:3] alertPinOe)
    else $error("no alert after eoc conversion");
  a_write_answer: assert property (wrTake |-> ##[1:2] s_axi_bvalid)
    else $error("write response missing");
  a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read data missing");
endmodule
`default_nettype wire

// File: sim/alert_host_model.sv
// Purpose: host side of the shared alert line
// Assumes: one pull-up on the alert line
// Notes: alert response pulses one cycle per request cycle
`timescale 1ns/10ps
`default_nettype none
module alert_host_model (
  input wire sys_clk,
  input wire rst_b,
  input wire respReq,
  input wire alertPinOut,
  input wire alertPinOe,
  output wire alertLine,
  output logic alertResp
);
  // released pin floats up through the pull-up
  assign alertLine = alertPinOe ? alertPinOut : 1'b1;
  // alert response issued on request
  always @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      alertResp <= 1'b0;
    end else begin
      alertResp <= respReq;
    end
  end
endmodule
`default_nettype wire

// File: sim/light_threshold_alert_logic_bench.sv
// Purpose: self-checking bench for the light threshold alert logic
// Assumes: 20 MHz clock, registers reached over the register bus
// Notes: alert seen as the resolved line level
`timescale 1ns/10ps
`default_nettype none
`include "light_alert_map.vh"
`define CHK(n, e, a) begin checks_done++; if ((a) !== (e)) begin mismatches++; \
  $display("MISMATCH %s expected %h seen %h", n, e, a); end end
module light_threshold_alert_logic_bench;
  logic sys_clk = 1'b0;
  logic rst_b = 1'b0;
  logic [3:0] s_axi_awaddr = 4'h0, s_axi_araddr = 4'h0, s_axi_wstrb = 4'hF;
  logic [31:0] s_axi_wdata = 32'h0, d;
  logic [15:0] convResult = 16'h0;
  logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0;
  logic s_axi_rready = 0, convDone = 0, respReq = 0;
  logic [1:0] lastResp;
  wire s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  wire alertRespAck, alertPinOut, alertPinOe, alertResp, alertLine;
  wire [1:0] s_axi_bresp, s_axi_rresp;
  wire [31:0] s_axi_rdata;
  int mismatches = 0;
  int checks_done = 0;
  int cycles = 0;
  logic [3:0] ackCount = 4'h0;
  light_threshold_alert_logic light_threshold_alert_logic_i (.sys_clk, .rst_b, .s_axi_awaddr,
    .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
    .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
    .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .convDone, .convResult,
    .alertResp, .alertRespAck, .alertPinOut, .alertPinOe);
  alert_host_model alert_host_model_i (.sys_clk, .rst_b, .respReq, .alertPinOut, .alertPinOe,
    .alertLine, .alertResp);
  // clock and hang guard
  initial forever #25 sys_clk = ~sys_clk;
  always @(posedge sys_clk) begin
    cycles <= cycles + 1;
    ackCount <= ackCount + {3'h0, alertRespAck};
    if (cycles == 5000) begin
      mismatches++;
      finish_test;
    end
  end
  task finish_test;
    $display("checks %0d mismatches %0d", checks_done, mismatches);
    if (mismatches == 0 && checks_done > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  // register bus write: valid held until each channel is taken
  task wr(input [3:0] a, input [31:0] v);
    @(posedge sys_clk);
    s_axi_awaddr <= a;
    s_axi_wdata <= v;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge sys_clk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (s_axi_awvalid || s_axi_wvalid);
    while (!s_axi_bvalid) @(posedge sys_clk);
    lastResp = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask
  task rd(input [3:0] a, output [31:0] v);
    @(posedge sys_clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do @(posedge sys_clk); while (!s_axi_arready);
    s_axi_arvalid <= 1'b0;
    do @(posedge sys_clk); while (!s_axi_rvalid);
    v = s_axi_rdata;
    `CHK("rresp", `RESP_OKAY, s_axi_rresp)
    s_axi_rready <= 1'b0;
  endtask
  task expRd(input string n, input [3:0] a, input [31:0] e);
    logic [31:0] v;
    rd(a, v);
    `CHK(n, e, v)
  endtask
  task expLine(input logic e);
    repeat (3) @(posedge sys_clk);
    `CHK("alert line", e, alertLine)
  endtask
  // one conversion pulse, then time for flags and pin to settle
  task conv(input [15:0] v);
    @(posedge sys_clk);
    convDone <= 1'b1;
    convResult <= v;
    @(posedge sys_clk);
    convDone <= 1'b0;
    repeat (4) @(posedge sys_clk);
  endtask
  task resp;
    @(posedge sys_clk);
    respReq <= 1'b1;
    @(posedge sys_clk);
    respReq <= 1'b0;
    repeat (4) @(posedge sys_clk);
  endtask
  task t_reset;
    expRd("cfg", `CFG_ADDR, 32'h00000010);
    expRd("high", `HIGH_LIMIT_ADDR, 32'h0000BFFF);
    expRd("low", `LOW_LIMIT_ADDR, 32'h00000000);
    expRd("status", `STATUS_ADDR, 32'h00000002);
    expLine(1'b1);
    wr(`STATUS_ADDR, 32'h0000FFFF);
    `CHK("bresp", `RESP_SLVERR, lastResp)
    wr(`HIGH_LIMIT_ADDR, 32'h00001000);
    wr(`LOW_LIMIT_ADDR, 32'h00000100);
    $display("reset test done");
  endtask
  task t_latch_high;
    wr(`CFG_ADDR, 32'h00000011);
    conv(16'h2000);
    conv(16'h0800);
    conv(16'h2000);
    expLine(1'b1);
    conv(16'h2000);
    expLine(1'b0);
    expRd("cfg", `CFG_ADDR, 32'h000000D1);
    expLine(1'b1);
    expRd("cfg", `CFG_ADDR, 32'h00000011);
    $display("latched high test done");
  endtask
  task t_latch_low;
    conv(16'h0010);
    conv(16'h0010);
    expLine(1'b0);
    resp;
    expLine(1'b1);
    `CHK("ack", 4'h1, ackCount)
    expRd("cfg", `CFG_ADDR, 32'h000000B1);
    $display("latched low test done");
  endtask
  task t_mode_write;
    conv(16'h2000);
    conv(16'h2000);
    wr(`CFG_ADDR, 32'h00000211);
    expLine(1'b0);
    expRd("cfg", `CFG_ADDR, 32'h00000251);
    conv(16'h0800);
    wr(`CFG_ADDR, 32'h00000011);
    expRd("cfg", `CFG_ADDR, 32'h00000091);
    $display("mode write test done");
  endtask
  task t_transparent;
    wr(`CFG_ADDR, 32'h00000001);
    conv(16'h2000);
    conv(16'h2000);
    expLine(1'b0);
    expRd("cfg", `CFG_ADDR, 32'h000000C1);
    expLine(1'b0);
    resp;
    expLine(1'b0);
    `CHK("ack", 4'h1, ackCount)
    conv(16'h0010);
    conv(16'h0010);
    expLine(1'b1);
    expRd("cfg", `CFG_ADDR, 32'h000000A1);
    wr(`CFG_ADDR, 32'h00000009);
    expLine(1'b0);
    $display("transparent test done");
  endtask
  task t_fault_count;
    wr(`CFG_ADDR, 32'h00000013);
    repeat (7) conv(16'h2000);
    expLine(1'b1);
    conv(16'h2000);
    expLine(1'b0);
    expRd("cfg", `CFG_ADDR, 32'h000000F3);
    $display("fault count test done");
  endtask
  task t_eoc;
    wr(`CFG_ADDR, 32'h00000010);
    wr(`HIGH_LIMIT_ADDR, 32'h0000FFFF);
    wr(`LOW_LIMIT_ADDR, 32'h0000C000);
    conv(16'h0800);
    expLine(1'b0);
    rd(`CFG_ADDR, d);
    `CHK("ready", 1'b1, d[`CFG_READY_BIT])
    expLine(1'b1);
    conv(16'h0800);
    expLine(1'b0);
    resp;
    expLine(1'b1);
    `CHK("ack", 4'h2, ackCount)
    $display("eoc test done");
  endtask
  initial begin
    repeat (20) @(posedge sys_clk);
    rst_b <= 1'b1;
    t_reset;
    t_latch_high;
    t_latch_low;
    t_mode_write;
    t_transparent;
    t_fault_count;
    t_eoc;
    finish_test;
  end
endmodule
bind light_threshold_alert_logic light_threshold_alert_logic_assertions light_threshold_alert_logic_assertions_i (
  .sys_clk, .rst_b, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wvalid,
  .s_axi_wready, .s_axi_bvalid, .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid, .convDone,
  .alertResp, .alertRespAck, .alertPinOut, .alertPinOe);
`default_nettype wire
